// ==== ebs_pkg.sv ====
// package for the external bus cycle phase sequencer
package ebs_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  localparam int CNT_W = 5;
  localparam logic [4:0] ACC_MAX = 5'h1f; // access code 31 means 32 periods
  localparam logic [4:0] ONE_PERIOD = 5'h01;
  localparam logic [4:0] ZERO_PERIOD = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam int WIN_LSB = 16; // address window = bits above the shared-line width

  // per chip select timing configuration
  typedef struct packed {
    logic       setup_two;   // address setup 1 or 2 periods
    logic [1:0] win_extra;   // 0..3 extra setup periods on window change
    logic [1:0] cmd_delay;   // 0..3
    logic       wr_setup;    // 0..1
    logic [4:0] access_m1;   // access length minus one, 1..32
    logic [1:0] hold;        // 0..3
    logic       rdy_en;      // ready stretches access
    logic       rdy_pol;     // 1: ready active high
    logic       rdy_async;   // ready passes a synchroniser
    logic       multiplexed_bus_mode;    // 1: multiplexed, 0: separate
  } ebs_cs_cfg_t;

  typedef struct packed {
    logic              write;
    logic [CS_W-1:0]   cs;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebs_req_t;

  typedef enum logic [2:0] {
    EBS_IDLE   = 3'b000,
    EBS_SETUP  = 3'b001,
    EBS_CMD    = 3'b010,
    EBS_WSETUP = 3'b011,
    EBS_ACCESS = 3'b100,
    EBS_HOLD   = 3'b101
  } ebs_phase_t;
endpackage

// ==== ebs_ready_sync.sv ====
// ready input polarity and optional two-stage synchroniser
`timescale 1ns/1ps
module ebs_ready_sync (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ready_in,
  input wire logic pol_in,
  input wire logic async_in,
  output logic active_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ebs_sync_t;
  ebs_sync_t st_reg;
  ebs_sync_t st_next;

  // first stage is read only by the second
  always_comb begin
    st_next = st_reg;
    st_next.s1 = ready_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // async path costs two waitstates; sync path is used direct for shortest cycle
  assign active_out = (async_in ? st_reg.s2 : ready_in) == pol_in;
endmodule

// ==== ebs_sequencer.sv ====
// external bus cycle phase sequencer top
//
// How it works
// - each cycle runs setup, command delay, write setup, access, hold in order
// - phase lengths come from the selected chip select timing config
// - setup is 1 or 2 periods, plus 0..3 when address window changes
// - command 0..3, write setup 0..1, access 1..32, hold 0..3 periods
// - with ready enabled, access stretches until ready is seen active
// - read data captured on the edge that raises read strobe; address holds until the next request
// - multiplexed puts address then data on shared lines; separate uses own lines
// - ready polarity is selectable per chip select
// - asynchronous ready passes a synchroniser, costing two waitstates
// - ready inactive at sample adds a waitstate, active ends the access phase
`timescale 1ns/1ps
module ebs_sequencer (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire ebs_pkg::ebs_cs_cfg_t [ebs_pkg::NUM_CS-1:0] chip_select_timing_config_in,
  input wire logic req_valid_in,
  input wire ebs_pkg::ebs_req_t req_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [ebs_pkg::DATA_W-1:0] rdata_out,
  input wire logic ready_in,
  output logic [ebs_pkg::ADDR_W-1:0] address_lines_out,
  output logic [ebs_pkg::DATA_W-1:0] shared_addr_data_lines_out,
  output logic shared_addr_data_lines_oe_out,
  input wire logic [ebs_pkg::DATA_W-1:0] shared_addr_data_lines_in,
  output logic [ebs_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic [ebs_pkg::DATA_W-1:0] data_lines_in,
  output logic addr_latch_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [ebs_pkg::NUM_CS-1:0] cs_n_out,
  output logic [ebs_pkg::CNT_W-1:0] phase_out
);
  typedef struct packed {
    ebs_pkg::ebs_phase_t phase;
    logic [ebs_pkg::CNT_W-1:0] cnt;
    ebs_pkg::ebs_req_t req;
    ebs_pkg::ebs_cs_cfg_t cfg;
    logic [ebs_pkg::ADDR_W-ebs_pkg::WIN_LSB-1:0] last_win;
    logic [ebs_pkg::CS_W-1:0] last_cs;
    logic win_valid;
    logic [ebs_pkg::DATA_W-1:0] rdata;
    logic done;
    logic [ebs_pkg::ADDR_W-1:0] addr_o;
    logic [ebs_pkg::DATA_W-1:0] ad_o;
    logic ad_oe;
    logic [ebs_pkg::DATA_W-1:0] d_o;
    logic d_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [ebs_pkg::NUM_CS-1:0] cs_n;
  } ebs_state_t;

  ebs_state_t st_reg;
  ebs_state_t st_next;
  logic rdy_active;

  // setup length: base 1/2 plus window-change extension, up to five
  function automatic logic [ebs_pkg::CNT_W-1:0] setup_len(input ebs_pkg::ebs_cs_cfg_t c, input logic chg);
    logic [ebs_pkg::CNT_W-1:0] n;
    n = {4'h0, c.setup_two} + ebs_pkg::ONE_PERIOD;
    if (chg) begin
      n = n + {3'h0, c.win_extra};
    end
    return n;
  endfunction

  // next phase of non-zero length; a zero-length phase costs no clock at all
  function automatic ebs_pkg::ebs_phase_t next_phase(input ebs_pkg::ebs_phase_t p,
    input ebs_pkg::ebs_cs_cfg_t c);
    ebs_pkg::ebs_phase_t n;
    n = ebs_pkg::EBS_IDLE;
    case (p)
      ebs_pkg::EBS_IDLE: begin
        n = ebs_pkg::EBS_SETUP;
      end
      ebs_pkg::EBS_SETUP: begin
        n = (c.cmd_delay != '0) ? ebs_pkg::EBS_CMD : (c.wr_setup ? ebs_pkg::EBS_WSETUP : ebs_pkg::EBS_ACCESS);
      end
      ebs_pkg::EBS_CMD: begin
        n = c.wr_setup ? ebs_pkg::EBS_WSETUP : ebs_pkg::EBS_ACCESS;
      end
      ebs_pkg::EBS_WSETUP: begin
        n = ebs_pkg::EBS_ACCESS;
      end
      ebs_pkg::EBS_ACCESS: begin
        n = (c.hold != '0) ? ebs_pkg::EBS_HOLD : ebs_pkg::EBS_IDLE;
      end
      default: begin
        n = ebs_pkg::EBS_IDLE;
      end
    endcase
    return n;
  endfunction

  // periods of phase p minus one; only ever asked for phases of non-zero length
  function automatic logic [ebs_pkg::CNT_W-1:0] phase_len(input ebs_pkg::ebs_phase_t p,
    input ebs_pkg::ebs_cs_cfg_t c);
    logic [ebs_pkg::CNT_W-1:0] n;
    n = ebs_pkg::ZERO_PERIOD;
    case (p)
      ebs_pkg::EBS_CMD: begin
        n = {3'h0, c.cmd_delay} - ebs_pkg::ONE_PERIOD;
      end
      ebs_pkg::EBS_WSETUP: begin
        n = {4'h0, c.wr_setup} - ebs_pkg::ONE_PERIOD;
      end
      ebs_pkg::EBS_ACCESS: begin
        n = c.access_m1;
      end
      ebs_pkg::EBS_HOLD: begin
        n = {3'h0, c.hold} - ebs_pkg::ONE_PERIOD;
      end
      default: begin
        n = ebs_pkg::ZERO_PERIOD;
      end
    endcase
    return n;
  endfunction

  ebs_ready_sync u_rdy (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ready_in(ready_in),
    .pol_in(st_reg.cfg.rdy_pol),
    .async_in(st_reg.cfg.rdy_async),
    .active_out(rdy_active)
  );

  // phase sequencing; counters hold remaining periods minus one
  always_comb begin
    logic chg;
    logic last;
    logic step;
    ebs_pkg::ebs_phase_t nxt;
    chg = 1'b0;
    last = (st_reg.cnt == ebs_pkg::ZERO_PERIOD);
    step = 1'b0;
    nxt = next_phase(st_reg.phase, st_reg.cfg);
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.ale = 1'b0;
    case (st_reg.phase)
      ebs_pkg::EBS_IDLE: begin
        if (req_valid_in) begin
          st_next.req = req_in;
          st_next.cfg = chip_select_timing_config_in[req_in.cs];
          chg = !st_reg.win_valid || st_reg.last_cs != req_in.cs ||
                st_reg.last_win != req_in.addr[ebs_pkg::ADDR_W-1:ebs_pkg::WIN_LSB];
          st_next.cnt = setup_len(chip_select_timing_config_in[req_in.cs], chg) - ebs_pkg::ONE_PERIOD;
          st_next.phase = ebs_pkg::EBS_SETUP;
          st_next.addr_o = req_in.addr;
          st_next.cs_n = ~(ebs_pkg::NUM_CS'(1) << req_in.cs);
          st_next.last_cs = req_in.cs;
          st_next.last_win = req_in.addr[ebs_pkg::ADDR_W-1:ebs_pkg::WIN_LSB];
          st_next.win_valid = 1'b1;
          st_next.d_oe = 1'b0;
          if (chip_select_timing_config_in[req_in.cs].multiplexed_bus_mode) begin
            st_next.ad_o = req_in.addr[ebs_pkg::DATA_W-1:0];
            st_next.ad_oe = 1'b1;
            st_next.ale = 1'b1;
          end else begin
            st_next.ad_oe = 1'b0;
          end
        end
      end
      ebs_pkg::EBS_SETUP: begin
        st_next.ale = st_reg.cfg.multiplexed_bus_mode && !last; // latch strobe across setup
        if (last) begin
          step = 1'b1;
          // shared lines released for read, carry data for write
          st_next.ad_oe = st_reg.cfg.multiplexed_bus_mode && st_reg.req.write;
          st_next.ad_o = st_reg.req.wdata;
          st_next.d_oe = !st_reg.cfg.multiplexed_bus_mode && st_reg.req.write;
          st_next.d_o = st_reg.req.wdata;
        end else begin
          st_next.cnt = st_reg.cnt - ebs_pkg::ONE_PERIOD;
        end
      end
      ebs_pkg::EBS_CMD, ebs_pkg::EBS_WSETUP, ebs_pkg::EBS_HOLD: begin
        // plain timed phases: count down, then step on
        step = last;
        if (!last) begin
          st_next.cnt = st_reg.cnt - ebs_pkg::ONE_PERIOD;
        end
      end
      ebs_pkg::EBS_ACCESS: begin
        if (!last) begin
          st_next.cnt = st_reg.cnt - ebs_pkg::ONE_PERIOD;
        end else if (!st_reg.cfg.rdy_en || rdy_active) begin
          // this edge raises the strobe and captures read data
          step = 1'b1;
          st_next.rd_n = 1'b1;
          st_next.wr_n = 1'b1;
          if (!st_reg.req.write) begin
            st_next.rdata = st_reg.cfg.multiplexed_bus_mode ? shared_addr_data_lines_in : data_lines_in;
          end
        end
      end
      default: begin
        st_next.phase = ebs_pkg::EBS_IDLE;
      end
    endcase
    // entering a phase loads its length; strobes open on access, the cycle closes on idle
    if (step) begin
      st_next.phase = nxt;
      st_next.cnt = phase_len(nxt, st_reg.cfg);
      if (nxt == ebs_pkg::EBS_ACCESS) begin
        st_next.rd_n = st_reg.req.write;
        st_next.wr_n = !st_reg.req.write;
      end
      if (nxt == ebs_pkg::EBS_IDLE) begin
        st_next.done = 1'b1;
        st_next.cs_n = '1;
        st_next.ad_oe = 1'b0;
        st_next.d_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.rd_n <= 1'b1;
      st_reg.wr_n <= 1'b1;
      st_reg.cs_n <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_ready_out = (st_reg.phase == ebs_pkg::EBS_IDLE);
  assign done_out = st_reg.done;
  assign rdata_out = st_reg.rdata;
  assign address_lines_out = st_reg.addr_o;
  assign shared_addr_data_lines_out = st_reg.ad_o;
  assign shared_addr_data_lines_oe_out = st_reg.ad_oe;
  assign data_lines_out = st_reg.d_o;
  assign data_lines_oe_out = st_reg.d_oe;
  assign addr_latch_out = st_reg.ale;
  assign rd_n_out = st_reg.rd_n;
  assign wr_n_out = st_reg.wr_n;
  assign cs_n_out = st_reg.cs_n;
  assign phase_out = {2'h0, st_reg.phase};
endmodule

// ==== ebs_seq_properties.sv ====
// port assertions for the phase sequencer
`timescale 1ns/1ps
module ebs_seq_properties (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic addr_latch_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic [ebs_pkg::NUM_CS-1:0] cs_n_out,
  input wire logic [ebs_pkg::CNT_W-1:0] phase_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // phases only step forward, empty ones skipped; access or hold falls back to idle
  phase_order_a: assert property ($changed(phase_out) |-> phase_out > $past(phase_out) ||
    phase_out == 5'h00 && $past(phase_out) >= 5'h04) else $error("phase out of order");
  take_setup_a: assert property (req_valid_in && req_ready_out |=> phase_out == 5'h01) else $error("no setup");
  busy_refuse_a: assert property (req_ready_out == (phase_out == 5'h00)) else $error("ready while busy");
  strobe_access_a: assert property (!rd_n_out || !wr_n_out |-> phase_out == 5'h04) else $error("stray strobe");
  done_pulse_a: assert property (done_out |-> $past(phase_out) >= 5'h04 ##1 !done_out) else $error("bad done");
  setup_max_a: assert property ((phase_out == 5'h01) [*5] |=> phase_out != 5'h01) else $error("long setup");
  cmd_max_a: assert property ((phase_out == 5'h02) [*3] |=> phase_out != 5'h02) else $error("long command");
  hold_max_a: assert property ((phase_out == 5'h05) [*3] |=> phase_out == 5'h00) else $error("long hold");
  ale_setup_a: assert property (addr_latch_out |-> phase_out == 5'h01) else $error("latch outside setup");
  cs_one_a: assert property (phase_out != 5'h00 |-> $onehot(~cs_n_out)) else $error("bad select");
  cover property (!rd_n_out ##1 rd_n_out);
  cover property (!wr_n_out ##1 wr_n_out);
  cover property ((phase_out == 5'h04) [*3]);
endmodule

// ==== ebs_mem_model.sv ====
// behavioural memory on the far side of the bus
`timescale 1ns/1ps
module ebs_mem_model (
  input wire logic clk_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic ale_in,
  input wire logic mux_in,
  input wire logic pol_in,
  input wire logic [3:0] wait_in,
  input wire logic [15:0] ad_in,
  input wire logic ad_oe_in,
  input wire logic [15:0] d_in,
  input wire logic d_oe_in,
  input wire logic [23:0] a_in,
  output logic ready_out,
  output logic [15:0] rd_out,
  output logic [15:0] wd_out
);
  logic [15:0] lat;
  logic [3:0] cnt = 4'h0;
  wire [15:0] pat = (mux_in ? lat : a_in[15:0]) ^ 16'h5a5a;
  // released lines show the inverse so stale data cannot pass
  assign rd_out = !rd_n_in ? pat : ~pat;
  // ready after wait_in strobe cycles, dropped with the strobe
  assign ready_out = pol_in ~^ (!(rd_n_in && wr_n_in) && cnt >= wait_in);
  // a write seen without output enable stores junk on purpose
  always @(posedge clk_in) begin
    if (ale_in) lat <= ad_in;
    cnt <= (rd_n_in && wr_n_in) ? 4'h0 : cnt + 4'h1;
    if (!wr_n_in) wd_out <= mux_in ? (ad_oe_in ? ad_in : 16'hdead) : (d_oe_in ? d_in : 16'hdead);
  end
endmodule

// ==== ebs_sequencer_tb.sv ====
// self-checking bench for the phase sequencer
`timescale 1ns/1ps
module ebs_sequencer_tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic vld = 1'b0;
  logic [3:0] wt = 4'h0;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  ebs_pkg::ebs_cs_cfg_t [3:0] cfg;
  ebs_pkg::ebs_req_t req = '0;
  logic rdy_o, done, ale, rd_n, wr_n, ad_oe, d_oe, rdy;
  logic [15:0] rdata, ad_o, d_o, rd_v, wd;
  logic [23:0] a_o;
  logic [3:0] cs_n, sel;
  logic [4:0] ph;
  always #25 mclk_in = ~mclk_in;
  ebs_sequencer i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .chip_select_timing_config_in(cfg), .req_valid_in(vld),
    .req_in(req), .req_ready_out(rdy_o), .done_out(done), .rdata_out(rdata), .ready_in(rdy), .address_lines_out(a_o),
    .shared_addr_data_lines_out(ad_o), .shared_addr_data_lines_oe_out(ad_oe), .shared_addr_data_lines_in(rd_v),
    .data_lines_out(d_o), .data_lines_oe_out(d_oe), .data_lines_in(rd_v), .addr_latch_out(ale), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .cs_n_out(cs_n), .phase_out(ph));
  ebs_mem_model i_mem (.clk_in(mclk_in), .rd_n_in(rd_n), .wr_n_in(wr_n), .ale_in(ale), .mux_in(cfg[req.cs].multiplexed_bus_mode),
    .pol_in(cfg[req.cs].rdy_pol), .wait_in(wt), .ad_in(ad_o), .ad_oe_in(ad_oe), .d_in(d_o), .d_oe_in(d_oe),
    .a_in(a_o), .ready_out(rdy), .rd_out(rd_v), .wd_out(wd));
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp) begin
      n_fail++;
      $display("BAD %0t act %h exp %h", $time, act, exp);
    end
  endtask
  // one bus cycle; n counts edges from take to done, bounded against a hang
  task automatic run(input logic w, input logic [1:0] c, input logic [23:0] a, input logic [15:0] d);
    req = '{w, c, a, d};
    vld = 1'b1;
    @(posedge mclk_in);
    #1 vld = 1'b0;
    sel = cs_n;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge mclk_in);
      #1 n++;
    end
  endtask
  // separate mode: first cycle after reset counts as a window change
  task automatic t_sep;
    chk(32'({rdy_o, rd_n, wr_n, ale, cs_n, ph}), 32'h1de0);
    run(1'b0, 2'h0, 24'h12abcd, 16'h0);
    chk(32'(n), 32'h4);
    chk(32'(rdata), 32'hf197);
    run(1'b0, 2'h0, 24'h120077, 16'h0);
    chk(32'(n), 32'h2);
    chk(32'(rdata), 32'h5a2d);
    run(1'b1, 2'h0, 24'h120010, 16'hbeef);
    chk(32'(wd), 32'hbeef);
  endtask
  // multiplexed mode with every phase at its longest; the read keeps its window, so its setup is 2
  task automatic t_mux;
    run(1'b1, 2'h1, 24'h340123, 16'hc3a5);
    chk(32'(n), 32'h2c);
    chk(32'(sel), 32'hd);
    chk(32'(wd), 32'hc3a5);
    run(1'b0, 2'h1, 24'h344321, 16'h0);
    chk(32'(n), 32'h29);
    chk(32'(rdata), 32'h197b);
  endtask
  // ready stretches access: low polarity, high polarity, then synchronised
  task automatic t_rdy;
    wt = 4'h3;
    run(1'b0, 2'h2, 24'h560000, 16'h0);
    chk(32'(n), 32'h5);
    cfg[2].rdy_pol = 1'b1;
    wt = 4'h1;
    run(1'b0, 2'h2, 24'h560002, 16'h0);
    chk(32'(n), 32'h3);
    cfg[2].rdy_async = 1'b1;
    run(1'b0, 2'h2, 24'h560004, 16'h0);
    chk(32'(n > 3), 32'h1);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    cfg[0] = '{1'b0, 2'h2, 2'h0, 1'b0, 5'h00, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0};
    cfg[1] = '{1'b1, 2'h3, 2'h3, 1'b1, ebs_pkg::ACC_MAX, 2'h3, 1'b0, 1'b1, 1'b0, 1'b1};
    cfg[2] = '{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0};
    cfg[3] = cfg[0];
    repeat (3) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    t_sep;
    t_mux;
    t_rdy;
    finish_test;
  end
  // watchdog: the tests take under 200 cycles
  initial begin
    #20000;
    n_fail++;
    finish_test;
  end
endmodule
bind ebs_sequencer ebs_seq_properties i_prop (.mclk_in(mclk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .done_out(done_out), .addr_latch_out(addr_latch_out), .rd_n_out(rd_n_out),
  .wr_n_out(wr_n_out), .cs_n_out(cs_n_out), .phase_out(phase_out));
